// ---- rtl/torque_off_defines.svh ----
// constants for the dual channel torque off interlock
`ifndef TORQUE_OFF_DEFINES_SVH
`define TORQUE_OFF_DEFINES_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ 20000000
`define PULSE_TOL_US 1000
// longest dropout ignored, rounded down to whole cycles
`define PULSE_TOL_CYC ((`CLK_FREQ_HZ / 1000000) * `PULSE_TOL_US)
// ----------------------------------------------------------------------
// indication selection setting codes
// ----------------------------------------------------------------------
`define SEL_FAULT_FAULT 2'h0
`define SEL_FAULT_WARN 2'h1
`define SEL_WARN_NONE 2'h2
`define SEL_NONE_NONE 2'h3
`endif

// ---- rtl/torque_off_pkg.sv ----
// types for the dual channel torque off interlock
package torque_off_pkg;
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_READY = 3'h2,
    ST_RUN = 3'h4
  } mode_t;
endpackage

// ---- rtl/torque_off_interlock.sv ----
// dual channel torque off interlock for a motor drive output stage
// Functional notes
// - a drop of either filtered input clears the gate enable at once.
// - the setting and the running state choose fault, warning or nothing.
// - the setting never changes the torque off action or the stop.
// - start is blocked until both inputs close and faults are reset.
// - loss of only one channel always raises a fault.
// - after a loss of both inputs, a reset is demanded only when the setting says so.
// - closing the inputs never starts; a fresh start edge is needed.
// - start while open and stopped raises a warning, motor stays off.
// - loss of channel one alone latches the channel one loss fault.
// - loss of channel two alone latches the channel two loss fault.
// - no braking output is ever driven when torque is removed.
// - dropouts of up to 1 ms on either input are ignored.
// - channels are compared and any disagreement trips a fault.
`timescale 1ns/100ps
`include "torque_off_defines.svh"
module torque_off_interlock #(
  parameter int TOL_CYC = `PULSE_TOL_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // torque off inputs, high when energised
  input wire logic FIRST_TORQUE_OFF_INPUT,
  input wire logic SECOND_TORQUE_OFF_INPUT,
  // control
  input wire logic START_CMD,
  input wire logic STOP_CMD,
  input wire logic FAULT_RESET,
  input wire logic [1:0] IND_SEL,
  // outputs
  output logic GATE_ENABLE,
  output logic BRAKE_OUT,
  output logic RUNNING,
  output logic TORQUE_OFF_ACTIVE,
  output logic CHANNEL_ONE_LOSS_FAULT,
  output logic CHANNEL_TWO_LOSS_FAULT,
  output logic TORQUE_OFF_FAULT,
  output logic TORQUE_OFF_WARNING,
  output logic START_BLOCKED_WARNING
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic f1;
    logic f2;
    logic [22:0] c1;
    logic [22:0] c2;
    logic start_prev;
    torque_off_pkg::mode_t mode;
    logic gate;
    logic ch1_fault;
    logic ch2_fault;
    logic sto_fault;
    logic sto_warn;
    logic blk_warn;
    logic need_reset;
    logic run;
    logic off;
  } state_t;

  state_t st_q;
  state_t st_d;
  logic both_ok;
  logic any_open;
  logic start_edge;
  logic any_fault;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // filter counts how long a raw level differs from the accepted one;
  // a change is accepted only after it outlasts the tolerance window
  always_comb begin
    st_d = st_q;
    st_d.s1 = {st_q.s1[0], FIRST_TORQUE_OFF_INPUT};
    st_d.s2 = {st_q.s2[0], SECOND_TORQUE_OFF_INPUT};
    // drop tolerance on channel one
    if (st_q.s1[1] == st_q.f1) begin
      st_d.c1 = '0;
    end else if (st_q.c1 >= 23'(TOL_CYC)) begin
      st_d.f1 = st_q.s1[1];
      st_d.c1 = '0;
    end else begin
      st_d.c1 = st_q.c1 + 23'h1;
    end
    // drop tolerance on channel two
    if (st_q.s2[1] == st_q.f2) begin
      st_d.c2 = '0;
    end else if (st_q.c2 >= 23'(TOL_CYC)) begin
      st_d.f2 = st_q.s2[1];
      st_d.c2 = '0;
    end else begin
      st_d.c2 = st_q.c2 + 23'h1;
    end
    st_d.start_prev = START_CMD;
    // fault reset, hardware set below wins over it
    if (FAULT_RESET) begin
      st_d.ch1_fault = 1'b0;
      st_d.ch2_fault = 1'b0;
      st_d.sto_fault = 1'b0;
      st_d.sto_warn = 1'b0;
      st_d.need_reset = 1'b0;
    end
    if (both_ok) begin
      st_d.blk_warn = 1'b0;
    end
    // channel disagreement always trips, whatever the setting
    if (st_q.f1 != st_q.f2) begin
      st_d.sto_fault = 1'b1;
      st_d.need_reset = 1'b1;
      // build on the cleared copy so a same-cycle reset still clears
      // the channel that is not failing now
      st_d.ch1_fault = st_d.ch1_fault | ~st_q.f1;
      st_d.ch2_fault = st_d.ch2_fault | ~st_q.f2;
    end else if (any_open && st_q.mode != torque_off_pkg::ST_OFF) begin
      // both channels dropped: indication picked by setting and state
      case (IND_SEL)
        `SEL_FAULT_FAULT: begin
          st_d.sto_fault = 1'b1;
          st_d.need_reset = 1'b1;
        end
        `SEL_FAULT_WARN: begin
          if (st_q.mode == torque_off_pkg::ST_RUN) begin
            st_d.sto_fault = 1'b1;
            st_d.need_reset = 1'b1;
          end else begin
            st_d.sto_warn = 1'b1;
          end
        end
        `SEL_WARN_NONE: begin
          // only ever set, so an older latched warning is kept
          if (st_q.mode == torque_off_pkg::ST_RUN) begin
            st_d.sto_warn = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // start attempt while open and stopped
    if (start_edge && any_open && st_q.mode != torque_off_pkg::ST_RUN) begin
      st_d.blk_warn = 1'b1;
    end
    // mode sequence; the setting plays no part here
    case (st_q.mode)
      torque_off_pkg::ST_OFF: begin
        if (both_ok) begin
          st_d.mode = torque_off_pkg::ST_READY;
        end
      end
      torque_off_pkg::ST_READY: begin
        if (any_open) begin
          st_d.mode = torque_off_pkg::ST_OFF;
        end else if (start_edge && !any_fault && !STOP_CMD) begin
          st_d.mode = torque_off_pkg::ST_RUN;
        end
      end
      torque_off_pkg::ST_RUN: begin
        if (any_open) begin
          st_d.mode = torque_off_pkg::ST_OFF;
        end else if (STOP_CMD) begin
          st_d.mode = torque_off_pkg::ST_READY;
        end
      end
      default: begin
        st_d.mode = torque_off_pkg::ST_OFF;
      end
    endcase
    // gate enable follows the next mode, so a drop clears it in one edge
    st_d.gate = (st_d.mode == torque_off_pkg::ST_RUN) && !any_open;
    // mode flags kept in flip-flops so the outputs need no decode
    st_d.run = st_d.mode == torque_off_pkg::ST_RUN;
    st_d.off = st_d.mode == torque_off_pkg::ST_OFF;
  end

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // start is edge sensitive so a held level cannot restart the motor
  assign both_ok = st_q.f1 & st_q.f2;
  assign any_open = ~st_q.f1 | ~st_q.f2;
  assign start_edge = START_CMD & ~st_q.start_prev;
  assign any_fault = st_q.need_reset | st_q.ch1_fault | st_q.ch2_fault;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // reset leaves the filters at open so torque stays off until sampled
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_q <= '{s1: 2'h0, s2: 2'h0, f1: 1'b0, f2: 1'b0, c1: 23'h0,
                c2: 23'h0, start_prev: 1'b1, mode: torque_off_pkg::ST_OFF,
                gate: 1'b0, ch1_fault: 1'b0, ch2_fault: 1'b0,
                sto_fault: 1'b0, sto_warn: 1'b0, blk_warn: 1'b0,
                need_reset: 1'b0, run: 1'b0, off: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops; no brake path exists at all
  assign GATE_ENABLE = st_q.gate;
  assign BRAKE_OUT = 1'b0;
  assign RUNNING = st_q.run;
  assign TORQUE_OFF_ACTIVE = st_q.off;
  assign CHANNEL_ONE_LOSS_FAULT = st_q.ch1_fault;
  assign CHANNEL_TWO_LOSS_FAULT = st_q.ch2_fault;
  assign TORQUE_OFF_FAULT = st_q.sto_fault;
  assign TORQUE_OFF_WARNING = st_q.sto_warn;
  assign START_BLOCKED_WARNING = st_q.blk_warn;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  gate_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    any_open |=> !GATE_ENABLE) else $error("gate on while open");
  no_brake_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !BRAKE_OUT) else $error("brake driven");
  start_open_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !both_ok && !GATE_ENABLE |=> !GATE_ENABLE)
    else $error("start while open");
  fault_block_a: assert property (@(posedge CLK) disable iff (!RST_N)
    any_fault && !GATE_ENABLE |=> !GATE_ENABLE)
    else $error("start with fault latched");
  fresh_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(GATE_ENABLE) |-> $past(start_edge))
    else $error("start without edge");
  single_loss_a: assert property (@(posedge CLK) disable iff (!RST_N)
    st_q.f1 != st_q.f2 |=> TORQUE_OFF_FAULT)
    else $error("single loss no fault");
  ch_one_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !st_q.f1 && st_q.f2 |=> CHANNEL_ONE_LOSS_FAULT)
    else $error("channel one fault missing");
  ch_two_a: assert property (@(posedge CLK) disable iff (!RST_N)
    st_q.f1 && !st_q.f2 |=> CHANNEL_TWO_LOSS_FAULT)
    else $error("channel two fault missing");
  blocked_warn_a: assert property (@(posedge CLK) disable iff (!RST_N)
    start_edge && any_open && !RUNNING |=> START_BLOCKED_WARNING)
    else $error("no blocked start warning");
  run_stop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    RUNNING && any_open |=> !RUNNING)
    else $error("run kept while open");
  short_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    st_q.f1 && !st_q.s1[1] && st_q.c1 == 23'h0 |=> st_q.f1)
    else $error("short drop accepted");
  filter_init_a: assert property (@(posedge CLK)
    !RST_N |=> !GATE_ENABLE && TORQUE_OFF_ACTIVE)
    else $error("reset state wrong");
endmodule

// ---- testbench/torque_off_switch.sv ----
// activation switch model driving the two torque off contacts
`timescale 1ns/100ps
module torque_off_switch (
  // clock
  input wire logic clk,
  // requested contact states, high = closed
  input wire logic want_one,
  input wire logic want_two,
  // contacts wired to the drive
  output logic contact_one,
  output logic contact_two
);
  // requests start open so the drive powers up with torque removed
  logic one_q = 1'b0;
  logic two_q = 1'b0;
  // take the requests on the rising edge, away from the bench's edge,
  // so the contact timing never depends on process order
  always @(posedge clk) begin
    one_q <= want_one;
    two_q <= want_two;
  end
  // both contacts move on the same falling edge, as the interlock tolerates no skew between channels;
  // a bench that opens one contact only for longer than the tolerance is staging a wiring fault
  always @(negedge clk) begin
    contact_one <= one_q;
    contact_two <= two_q;
  end
endmodule

// ---- testbench/torque_off_interlock_tb_top.sv ----
// self-checking bench for the torque off interlock
`timescale 1ns/100ps
module torque_off_interlock_tb_top;
  // ----------------------------------------------------------------------
  // clock, stimulus and design
  // ----------------------------------------------------------------------
  localparam int TOL = 4;
  logic clk = 1'b0, rst_n = 1'b0, want_one = 1'b0, want_two = 1'b0;
  logic start = 1'b0, stop = 1'b0, freset = 1'b0;
  logic [1:0] sel = 2'h0;
  logic in_one, in_two, gate, brake, run, off, f1, f2, flt, warn, blk;
  int num_errors = 0;
  int compares = 0;
  // 20 MHz
  always #25 clk = ~clk;
  torque_off_switch torque_off_switch_i (.clk(clk), .want_one(want_one),
    .want_two(want_two), .contact_one(in_one), .contact_two(in_two));
  torque_off_interlock #(.TOL_CYC(TOL)) torque_off_interlock_i (
    .CLK(clk), .RST_N(rst_n), .FIRST_TORQUE_OFF_INPUT(in_one),
    .SECOND_TORQUE_OFF_INPUT(in_two), .START_CMD(start), .STOP_CMD(stop),
    .FAULT_RESET(freset), .IND_SEL(sel), .GATE_ENABLE(gate),
    .BRAKE_OUT(brake), .RUNNING(run), .TORQUE_OFF_ACTIVE(off),
    .CHANNEL_ONE_LOSS_FAULT(f1), .CHANNEL_TWO_LOSS_FAULT(f2),
    .TORQUE_OFF_FAULT(flt), .TORQUE_OFF_WARNING(warn),
    .START_BLOCKED_WARNING(blk));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask
  // partner 1, sync 2, filter TOL+1, register 1, plus a few of margin
  task automatic settle();
    ticks(TOL + 8);
  endtask
  // one-cycle strobe: 0 start, 1 stop, 2 fault reset; result due 2 later
  task automatic pulse(input int which);
    @(negedge clk);
    start = (which == 0);
    stop = (which == 1);
    freset = (which == 2);
    @(negedge clk);
    {start, stop, freset} = 3'h0;
    @(negedge clk);
  endtask
  task automatic outs(input logic g, input logic e1, input logic e2,
                      input logic ef, input logic ew);
    check("GATE_ENABLE", g, gate);
    check("RUNNING", g, run);
    check("BRAKE_OUT", 1'b0, brake);
    check("CHANNEL_ONE_LOSS_FAULT", e1, f1);
    check("CHANNEL_TWO_LOSS_FAULT", e2, f2);
    check("TORQUE_OFF_FAULT", ef, flt);
    check("TORQUE_OFF_WARNING", ew, warn);
  endtask
  task automatic stop_test();
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // both contacts open, drive running or stopped, for one setting
  task automatic dual_drop(input logic [1:0] s, input logic running);
    logic ef;
    logic ew;
    ef = (s == 2'h0) | ((s == 2'h1) & running);
    ew = running ? (s == 2'h2) : (s == 2'h1);
    sel = s;
    if (running) pulse(0);
    check("RUNNING", running, run);
    {want_one, want_two} = 2'h0;
    settle();
    outs(1'b0, 1'b0, 1'b0, ef, ew);
    check("TORQUE_OFF_ACTIVE", 1'b1, off);
    pulse(0);
    check("START_BLOCKED_WARNING", 1'b1, blk);
    check("GATE_ENABLE", 1'b0, gate);
    {want_one, want_two} = 2'h3;
    settle();
    check("RUNNING", 1'b0, run);
    check("START_BLOCKED_WARNING", 1'b0, blk);
    pulse(0);
    check("RUNNING", ~ef, run);
    pulse(1);
    pulse(2);
    pulse(0);
    check("RUNNING", 1'b1, run);
    pulse(1);
  endtask
  // one contact opened alone while running, staged wiring fault
  task automatic single_drop(input logic first);
    sel = 2'h3;
    pulse(0);
    want_one = ~first;
    want_two = first;
    settle();
    outs(1'b0, first, ~first, 1'b1, 1'b0);
    pulse(0);
    check("RUNNING", 1'b0, run);
    {want_one, want_two} = 2'h3;
    settle();
    pulse(0);
    check("RUNNING", 1'b0, run);
    pulse(2);
    pulse(0);
    check("RUNNING", 1'b1, run);
    pulse(1);
  endtask
  // dropout of exactly the tolerated length must not stop the drive
  task automatic short_dropout();
    pulse(0);
    want_two = 1'b0;
    ticks(TOL);
    want_two = 1'b1;
    settle();
    check("RUNNING", 1'b1, run);
    check("CHANNEL_TWO_LOSS_FAULT", 1'b0, f2);
    pulse(1);
  endtask
  // reset in mid-run with start held high: a held level must not restart
  task automatic mid_reset();
    pulse(0);
    start = 1'b1;
    rst_n = 1'b0;
    ticks(3);
    rst_n = 1'b1;
    check("GATE_ENABLE", 1'b0, gate);
    check("TORQUE_OFF_ACTIVE", 1'b1, off);
    settle();
    check("TORQUE_OFF_ACTIVE", 1'b0, off);
    check("RUNNING", 1'b0, run);
    start = 1'b0;
    pulse(0);
    check("RUNNING", 1'b1, run);
    pulse(1);
  endtask
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    ticks(3);
    rst_n = 1'b1;
    check("GATE_ENABLE", 1'b0, gate);
    check("TORQUE_OFF_ACTIVE", 1'b1, off);
    {want_one, want_two} = 2'h3;
    settle();
    check("TORQUE_OFF_ACTIVE", 1'b0, off);
    for (int s = 0; s < 4; s++) begin
      dual_drop(2'(s), 1'b1);
      dual_drop(2'(s), 1'b0);
    end
    single_drop(1'b1);
    single_drop(1'b0);
    short_dropout();
    mid_reset();
    stop_test();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end
endmodule
